/* logic/rcp_top.sv */
// Receiver configuration port: frame decoder and configuration words
`timescale 1ns/1ps
`include "rcp_defs.svh"
module rcp_top (
    // Clock and reset
    input  wire logic          CORE_CLK,
    input  wire logic          ARST_N,
    // Bidirectional data line
    input  wire logic          DATA_IN,
    output logic               DATA_OUT,
    output logic               DATA_OE,
    // Supply monitor
    input  wire logic          SUPPLY_DROP_IN,
    // Receiver control
    output logic               OFF_CMD,
    output logic               SUPPLY_LOSS,
    output logic               PROG_OUT,
    // Configuration view
    output logic [11:0]        OP_WORD,
    output logic [11:0]        LIMIT_WORD,
    output rcp_pkg::rcp_cfg_t  CFG,
    output logic [9:0]         TLIM_MIN_CYC,
    output logic [9:0]         TLIM_MAX_CYC
);
    import rcp_pkg::*;

    localparam logic [11:0] SYNC_CYC   = 12'(`RCP_CYC_DN(`RCP_T3_NS));
    localparam logic [11:0] MARK_CYC   = 12'(`RCP_CYC_DN(`RCP_MARK_NS));
    localparam logic [11:0] SETTLE_CYC = 12'(`RCP_CYC_UP(`RCP_SETTLE_NS));
    localparam logic [11:0] BIT1_CYC   = 12'(`RCP_CYC_UP(`RCP_BIT1_NS));
    localparam logic [11:0] GAP_CYC    = 12'(`RCP_CYC_DN(`RCP_GAP_NS));
    localparam logic [11:0] T1_CYC_0   = 12'(`RCP_CYC_UP(`RCP_T1_NS_0));
    localparam logic [11:0] T1_CYC_1   = 12'(`RCP_CYC_UP(`RCP_T1_NS_1));
    localparam logic [11:0] T1_CYC_2   = 12'(`RCP_CYC_UP(`RCP_T1_NS_2));
    localparam logic [11:0] T1_CYC_3   = 12'(`RCP_CYC_UP(`RCP_T1_NS_3));

    // State
    rcp_state_t  st_q;
    rcp_state_t  st_d;
    logic [11:0] cnt_q;
    logic [11:0] cnt_d;
    logic [3:0]  idx_q;
    logic [3:0]  idx_d;
    logic        addr_q;
    logic        addr_d;
    logic [11:0] sh_q;
    logic [11:0] sh_d;
    logic        drive_q;
    logic        drive_d;
    logic        off_q;
    logic        off_d;
    logic        wr_op;
    logic        wr_lim;

    // Configuration words
    logic [11:0] op_q;
    logic [11:0] lim_q;
    logic        marker_q;
    logic [1:0]  wr_mask_q;
    rcp_cfg_t    cfg_q;
    logic [9:0]  tmin_q;
    logic [9:0]  tmax_q;

    // Supply drop synchroniser
    logic        drop_s1_q;
    logic        drop_s2_q;
    logic        drop_s3_q;

    rcp_pulse_t  pulse;

    // Decode
    wire         listen    = (st_q == ST_IDLE) | (st_q == ST_BITS);
    wire         bit_val   = (pulse.len >= BIT1_CYC);
    wire [1:0]   baud      = op_q[`RCP_OP_BAUD_LSB +: 2];
    wire [4:0]   lim_min   = lim_q[`RCP_LIM_MIN_LSB +: 5];
    wire [4:0]   lim_max   = lim_q[`RCP_LIM_MAX_LSB +: 5];
    wire [3:0]   limit_scale_factor      = (baud == 2'h0) ? `RCP_LIMIT_SCALE_FACTOR_0 :
                             (baud == 2'h1) ? `RCP_LIMIT_SCALE_FACTOR_1 :
                             (baud == 2'h2) ? `RCP_LIMIT_SCALE_FACTOR_2 : `RCP_LIMIT_SCALE_FACTOR_3;
    wire [11:0]  t1_cyc    = (baud == 2'h0) ? T1_CYC_0 :
                             (baud == 2'h1) ? T1_CYC_1 :
                             (baud == 2'h2) ? T1_CYC_2 : T1_CYC_3;
    wire [11:0]  drive_len = marker_q ? MARK_CYC : SYNC_CYC;
    wire [11:0]  sh_next   = {bit_val, sh_q[11:1]};
    wire [9:0]   tmin_d    = {5'h00, lim_min} * {6'h00, limit_scale_factor};
    wire [4:0]   lim_max_m = (lim_max == 5'h00) ? 5'h00 : lim_max - 5'h01;
    wire [9:0]   tmax_d    = {5'h00, lim_max_m} * {6'h00, limit_scale_factor};
    wire         drop_evt  = drop_s2_q & ~drop_s3_q;
    wire [1:0]   wr_now    = {wr_op, wr_lim};
    wire [1:0]   mask_next = wr_mask_q | wr_now;

    rcp_pulse_meter u_meter (
        .clk    (CORE_CLK),
        .arst_n (ARST_N),
        .pin    (DATA_IN),
        .listen (listen),
        .pulse  (pulse)
    );

    // Frame sequencer
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        idx_d   = idx_q;
        addr_d  = addr_q;
        sh_d    = sh_q;
        drive_d = 1'b0;
        off_d   = 1'b0;
        wr_op   = 1'b0;
        wr_lim  = 1'b0;
        case (st_q)
            ST_IDLE: begin
                cnt_d = 12'h000;
                if (pulse.done && (pulse.len >= t1_cyc)) begin
                    st_d    = ST_SYNC;
                    drive_d = 1'b1;
                end
            end
            ST_SYNC: begin
                if (cnt_q == drive_len - 12'h001) begin
                    st_d  = ST_SETTLE;
                    cnt_d = 12'h000;
                end else begin
                    drive_d = 1'b1;
                    cnt_d   = cnt_q + 12'h001;
                end
            end
            ST_SETTLE: begin
                if (cnt_q == SETTLE_CYC - 12'h001) begin
                    st_d  = ST_BITS;
                    cnt_d = 12'h000;
                    idx_d = 4'h0;
                end else begin
                    cnt_d = cnt_q + 12'h001;
                end
            end
            ST_BITS: begin
                if (pulse.done) begin
                    cnt_d = 12'h000;
                    idx_d = idx_q + 4'h1;
                    if (idx_q == 4'h0) begin
                        if (bit_val) begin
                            off_d = 1'b1;
                            st_d  = ST_IDLE;
                        end
                    end else if (idx_q == 4'h1) begin
                        addr_d = bit_val;
                    end else begin
                        sh_d = sh_next;
                        if (idx_q == `RCP_FRAME_BITS) begin
                            wr_op  = (addr_q == `RCP_ADDR_OPERATION_CONFIG_WORD);
                            wr_lim = (addr_q == `RCP_ADDR_LIMIT);
                            st_d   = ST_IDLE;
                        end
                    end
                end else if (pulse.low) begin
                    cnt_d = 12'h000;
                end else if (cnt_q == GAP_CYC - 12'h001) begin
                    st_d  = ST_IDLE;
                    cnt_d = 12'h000;
                end else begin
                    cnt_d = cnt_q + 12'h001;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_q    <= ST_IDLE;
            cnt_q   <= 12'h000;
            idx_q   <= 4'h0;
            addr_q  <= 1'b0;
            sh_q    <= 12'h000;
            drive_q <= 1'b0;
            off_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            idx_q   <= idx_d;
            addr_q  <= addr_d;
            sh_q    <= sh_d;
            drive_q <= drive_d;
            off_q   <= off_d;
        end
    end

    // Configuration words
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            op_q  <= `RCP_OP_RESET;
            lim_q <= `RCP_LIM_RESET;
        end else begin
            if (wr_op) begin
                op_q <= sh_next;
            end
            if (wr_lim) begin
                lim_q <= sh_next;
            end
        end
    end

    // Supply drop and marker
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            drop_s1_q <= 1'b0;
            drop_s2_q <= 1'b0;
            drop_s3_q <= 1'b0;
        end else begin
            drop_s1_q <= SUPPLY_DROP_IN;
            drop_s2_q <= drop_s1_q;
            drop_s3_q <= drop_s2_q;
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            marker_q  <= 1'b0;
            wr_mask_q <= 2'h0;
        end else if (drop_evt) begin
            marker_q  <= 1'b1;
            wr_mask_q <= 2'h0;
        end else if (mask_next == 2'h3) begin
            marker_q  <= 1'b0;
            wr_mask_q <= 2'h0;
        end else begin
            wr_mask_q <= marker_q ? mask_next : 2'h0;
        end
    end

    // Derived configuration outputs
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg_q  <= '0;
            tmin_q <= 10'h000;
            tmax_q <= 10'h000;
        end else begin
            cfg_q.baud    <= baud;
            cfg_q.limit_scale_factor    <= limit_scale_factor;
            cfg_q.lim_min <= lim_min;
            cfg_q.lim_max <= lim_max;
            cfg_q.programmable_output_bit    <= op_q[`RCP_OP_PROGRAMMABLE_OUTPUT_BIT_BIT];
            tmin_q        <= tmin_d;
            tmax_q        <= tmax_d;
        end
    end

    assign DATA_OUT     = 1'b0;
    assign DATA_OE      = drive_q;
    assign OFF_CMD      = off_q;
    assign SUPPLY_LOSS  = marker_q;
    assign PROG_OUT     = op_q[`RCP_OP_PROGRAMMABLE_OUTPUT_BIT_BIT];
    assign OP_WORD      = op_q;
    assign LIMIT_WORD   = lim_q;
    assign CFG          = cfg_q;
    assign TLIM_MIN_CYC = tmin_q;
    assign TLIM_MAX_CYC = tmax_q;

endmodule

/* common/rcp_defs.svh */
// Constants of the receiver configuration port
// How it works
// - Two 12-bit writable words hold operation configuration and bit-check window.
// - Registers are written only through frames on the bidirectional data line.
// - After a supply drop a long marker low replaces the sync; host reprograms both.
// - Power-on reset loads default values into both configuration words.
// - First frame bit 1 is an OFF command; receiver returns to polling.
// - First bit 0, second bit 1 writes payload into operation configuration word.
// - First bit 0, second bit 0 writes payload into bit-check window word.
// - Second frame bit is the register address selecting the target word.
// - Baud-range select picks the data-rate range and the limit scale factor.
// - Lower count times limit scale factor gives the lower time limit; upper count minus one (0 stays 0) times it gives the upper.
// - Programmable output bit drives its pin; 1 reduces sensitivity.
// - Programmable output bit resets to 0, full sensitivity.
// - Bit-check window word holds 5-bit lower and 5-bit upper counts.
// - Device answers each frame start with exactly one sync pulse, or with the long marker low after a supply drop.
`ifndef RCP_DEFS_SVH
`define RCP_DEFS_SVH

`define RCP_CLK_MHZ        100
`define RCP_REG_W          12
`define RCP_ADDR_LIMIT     1'h0
`define RCP_ADDR_OPERATION_CONFIG_WORD    1'h1
`define RCP_FRAME_BITS     4'hd
`define RCP_OP_RESET       12'h001
`define RCP_LIM_RESET      12'h30e
`define RCP_OP_BAUD_LSB    0
`define RCP_OP_PROGRAMMABLE_OUTPUT_BIT_BIT    11
`define RCP_LIM_MIN_LSB    0
`define RCP_LIM_MAX_LSB    5
`define RCP_LIMIT_SCALE_FACTOR_0         4'h8
`define RCP_LIMIT_SCALE_FACTOR_1         4'h4
`define RCP_LIMIT_SCALE_FACTOR_2         4'h2
`define RCP_LIMIT_SCALE_FACTOR_3         4'h1
`define RCP_T1_NS_0        20000
`define RCP_T1_NS_1        10000
`define RCP_T1_NS_2        5000
`define RCP_T1_NS_3        2500
`define RCP_T3_NS          1000
`define RCP_MARK_NS        3000
`define RCP_SETTLE_NS      40
`define RCP_BIT1_NS        2000
`define RCP_GAP_NS         30000
`define RCP_CYC_UP(ns)     (((ns) * `RCP_CLK_MHZ + 999) / 1000)
`define RCP_CYC_DN(ns)     (((ns) * `RCP_CLK_MHZ) / 1000)

`endif

/* common/rcp_pkg.sv */
// Types of the receiver configuration port
package rcp_pkg;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_SYNC   = 4'b0010,
        ST_SETTLE = 4'b0100,
        ST_BITS   = 4'b1000
    } rcp_state_t;

    typedef struct packed {
        logic        done;
        logic        low;
        logic [11:0] len;
    } rcp_pulse_t;

    typedef struct packed {
        logic [1:0] baud;
        logic [3:0] limit_scale_factor;
        logic [4:0] lim_min;
        logic [4:0] lim_max;
        logic       programmable_output_bit;
    } rcp_cfg_t;

endpackage

/* logic/rcp_pulse_meter.sv */
// Synchroniser and low-pulse width meter for the data line
`timescale 1ns/1ps
module rcp_pulse_meter (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          arst_n,
    // Line and control
    input  wire logic          pin,
    input  wire logic          listen,
    // Measured pulse
    output rcp_pkg::rcp_pulse_t pulse
);
    import rcp_pkg::*;

    logic        sync1_q;
    logic        sync2_q;
    logic [11:0] len_q;
    logic        done_q;
    logic [11:0] out_len_q;
    wire         line_low = ~sync2_q;
    wire         pulse_end = sync2_q & (len_q != 12'h000) & listen;
    wire         len_sat = (len_q == 12'hfff);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            len_q     <= 12'h000;
            done_q    <= 1'b0;
            out_len_q <= 12'h000;
        end else begin
            done_q <= pulse_end;
            if (pulse_end) begin
                out_len_q <= len_q;
            end
            if (!listen || !line_low) begin
                len_q <= 12'h000;
            end else if (!len_sat) begin
                len_q <= len_q + 12'h001;
            end
        end
    end

    assign pulse.done = done_q;
    assign pulse.low  = line_low & listen;
    assign pulse.len  = out_len_q;

endmodule

/* testbench/rcp_host_model.sv */
// Host microcontroller model on the open-drain data line
`timescale 1ns/1ps
module rcp_host_model (
    // Clock and line
    input  wire logic clk,
    input  wire logic oe_dev,
    // Line pull-down request
    output logic      low
);
    int sync_len = 0;
    bit tmo      = 1'b0;
    initial low = 1'b0;
    task automatic pulse(input int n);
        low <= 1'b1;
        repeat (n) @(posedge clk);
        low <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    // Start low, sync wait, then bits first to last
    task automatic frame(input logic [13:0] b, input int nb);
        int i;
        int n;
        pulse(2100);
        for (i = 0; i < 60 && !oe_dev; i++) @(negedge clk);
        for (n = 0; n < 400 && oe_dev; n++) @(negedge clk);
        tmo |= (n == 0 || n == 400);
        sync_len = n;
        repeat (8) @(posedge clk);
        for (i = 0; i < nb; i++) pulse(b[i] ? 250 : 20);
    endtask
endmodule

/* testbench/rcp_top_assertions.sv */
// Assertions on the receiver configuration port
`timescale 1ns/1ps
module rcp_top_assertions (
    // Clock and reset
    input wire logic             CORE_CLK,
    input wire logic             ARST_N,
    // Line and monitor
    input wire logic             DATA_OUT,
    input wire logic             DATA_OE,
    input wire logic             SUPPLY_DROP_IN,
    // Control and configuration
    input wire logic             OFF_CMD,
    input wire logic             SUPPLY_LOSS,
    input wire logic             PROG_OUT,
    input wire logic [11:0]      OP_WORD,
    input wire logic [11:0]      LIMIT_WORD,
    input wire rcp_pkg::rcp_cfg_t CFG,
    input wire logic [9:0]       TLIM_MIN_CYC,
    input wire logic [9:0]       TLIM_MAX_CYC
);
    import rcp_pkg::*;
    logic       up_q;
    logic [8:0] oe_cnt_q;
    wire  [1:0] op_baud = OP_WORD[1:0];
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            up_q     <= 1'b0;
            oe_cnt_q <= 9'h0;
        end else begin
            up_q     <= 1'b1;
            oe_cnt_q <= DATA_OE ? oe_cnt_q + 9'h1 : 9'h0;
        end
    end
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!ARST_N);
    chk_out_const: assert property (DATA_OUT == 1'b0)
        else $error("data out not low");
    chk_programmable_output_bit_bit: assert property (PROG_OUT == OP_WORD[11])
        else $error("prog out mismatch");
    chk_limit_scale_factor_map: assert property (up_q |-> CFG.limit_scale_factor == (4'h8 >> CFG.baud))
        else $error("limit_scale_factor mismatch");
    chk_baud_track: assert property (up_q |-> CFG.baud == $past(op_baud))
        else $error("baud not tracked");
    chk_tlim_min: assert property (up_q |->
        TLIM_MIN_CYC == {5'h0, CFG.lim_min} * {6'h0, CFG.limit_scale_factor})
        else $error("lower limit wrong");
    chk_tlim_max: assert property (up_q |-> TLIM_MAX_CYC == ((CFG.lim_max == 5'h0) ?
        10'h0 : ({5'h0, CFG.lim_max} - 10'h1) * {6'h0, CFG.limit_scale_factor}))
        else $error("upper limit wrong");
    chk_off_single: assert property (OFF_CMD |=> !OFF_CMD)
        else $error("off pulse too long");
    chk_off_words: assert property (OFF_CMD |-> $stable(OP_WORD) && $stable(LIMIT_WORD))
        else $error("off changed words");
    chk_oe_words: assert property (DATA_OE |-> $stable(OP_WORD) && $stable(LIMIT_WORD))
        else $error("word changed in sync");
    chk_sync_len: assert property ($fell(DATA_OE) |->
        oe_cnt_q == (SUPPLY_LOSS ? 9'h12c : 9'h064))
        else $error("sync length wrong");
    chk_loss_rise: assert property ($rose(SUPPLY_DROP_IN) |-> ##[3:5] SUPPLY_LOSS)
        else $error("loss not flagged");
    cov_off: cover property (OFF_CMD);
    cov_op: cover property ($changed(OP_WORD));
    cov_lim: cover property ($changed(LIMIT_WORD));
    cov_loss: cover property ($fell(SUPPLY_LOSS));
endmodule
bind rcp_top rcp_top_assertions i_chk (.CORE_CLK, .ARST_N, .DATA_OUT, .DATA_OE,
    .SUPPLY_DROP_IN, .OFF_CMD, .SUPPLY_LOSS, .PROG_OUT, .OP_WORD, .LIMIT_WORD,
    .CFG, .TLIM_MIN_CYC, .TLIM_MAX_CYC);

/* testbench/tb.sv */
// Self-checking bench of the receiver configuration port
`timescale 1ns/1ps
module tb;
    import rcp_pkg::*;
    logic        clk    = 1'b0;
    logic        arst_n = 1'b0;
    logic        drop   = 1'b0;
    logic        host_low;
    logic        oe, off_cmd, loss, prog_out;
    logic [11:0] op_word, lim_word;
    rcp_cfg_t    cfg;
    logic [9:0]  tmin, tmax;
    logic [11:0] op_e, lim_e;
    int          fails = 0;
    int          n_checks = 0;
    int          n_off = 0;
    always #5 clk = ~clk;
    always @(posedge clk) if (off_cmd === 1'b1) n_off <= n_off + 1;
    rcp_host_model i_host (.clk(clk), .oe_dev(oe), .low(host_low));
    rcp_top i_rcp_top (.CORE_CLK(clk), .ARST_N(arst_n), .DATA_IN(~(host_low | oe)),
        .DATA_OUT(), .DATA_OE(oe), .SUPPLY_DROP_IN(drop), .OFF_CMD(off_cmd),
        .SUPPLY_LOSS(loss), .PROG_OUT(prog_out), .OP_WORD(op_word), .LIMIT_WORD(lim_word),
        .CFG(cfg), .TLIM_MIN_CYC(tmin), .TLIM_MAX_CYC(tmax));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic [9:0] t_lim(input logic [9:0] l, input logic [11:0] op, bit hi);
        logic [9:0] x;
        x = 10'h8 >> op[1:0];
        if (hi) return (l == 10'h0) ? 10'h0 : (l - 10'h1) * x;
        return l * x;
    endfunction
    task automatic check_cfg();
        check("op_word", op_word, op_e);
        check("lim_word", lim_word, lim_e);
        check("prog_out", prog_out, op_e[11]);
        check("limit_scale_factor", cfg.limit_scale_factor, 4'h8 >> op_e[1:0]);
        check("cfg_baud", cfg.baud, op_e[1:0]);
        check("cfg_win", {cfg.lim_max, cfg.lim_min}, lim_e[9:0]);
        check("cfg_programmable_output_bit", cfg.programmable_output_bit, op_e[11]);
        check("tlim_min", tmin, t_lim({5'h0, lim_e[4:0]}, op_e, 1'b0));
        check("tlim_max", tmax, t_lim({5'h0, lim_e[9:5]}, op_e, 1'b1));
    endtask
    task automatic send(input logic [13:0] b, input int nb);
        i_host.frame(b, nb);
        if (i_host.tmo) begin
            fails++;
            print_verdict();
        end
    endtask
    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        op_e = 12'h001;
        lim_e = 12'h30e;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check_cfg();
        @(posedge clk);
        $display("test reset done");
    endtask
    task automatic write(input logic a, input logic [11:0] v, input int slen);
        send({v, a, 1'b0}, 14);
        if (a) op_e = v;
        else lim_e = v;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check_cfg();
        check("sync_len", i_host.sync_len, slen);
        @(posedge clk);
    endtask
    initial begin
        int i;
        logic [11:0] v;
        void'($urandom(91));
        do_reset();
        for (i = 0; i < 8; i++) begin
            v = 12'($urandom);
            v[1:0] = 2'(i >> 1);
            write(i[0], v, 100);
        end
        write(1'b0, 12'h01f, 100);
        write(1'b1, 12'hfff, 100);
        $display("test writes done");
        i = n_off;
        send(14'h1, 1);
        repeat (6) @(posedge clk);
        check("off_cmd", n_off - i, 1);
        check("op_keep", op_word, op_e);
        check("off_sync", i_host.sync_len, 100);
        $display("test off done");
        send({12'h000, 1'b1, 1'b0}, 5);
        repeat (3100) @(posedge clk);
        check("op_drop", op_word, op_e);
        check("lim_drop", lim_word, lim_e);
        write(1'b1, op_e ^ 12'h800, 100);
        $display("test short frame done");
        drop <= 1'b1;
        repeat (8) @(posedge clk);
        drop <= 1'b0;
        @(negedge clk);
        check("loss_set", loss, 1'b1);
        @(posedge clk);
        write(1'b1, 12'($urandom), 300);
        write(1'b0, 12'($urandom), 300);
        @(negedge clk);
        check("loss_clear", loss, 1'b0);
        @(posedge clk);
        $display("test supply loss done");
        do_reset();
        print_verdict();
    end
endmodule
